// ===== core_consts.vh
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH
// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define IDX_INDPORT 6'h00
`define IDX_PCBYTE 6'h02
`define IDX_STATUS 6'h03
`define IDX_PTR 6'h04
`define IDX_PCHI 6'h0A
`define IDX_CTRL 6'h10
`define IDX_WREG 6'h11
`define IDX_IREG 6'h12
// ----------------------------------------------------------------
// Core file addresses, mirrored in every bank
// ----------------------------------------------------------------
`define F_INDPORT 7'h00
`define F_PCBYTE 7'h02
`define F_STATUS 7'h03
`define F_PTR 7'h04
`define F_PCHI 7'h0A
// ----------------------------------------------------------------
// Status bit positions and reset values
// ----------------------------------------------------------------
`define ST_C 0
`define ST_DIGC 1
`define ST_Z 2
`define ST_PWRDN 3
`define ST_WDOG 4
`define ST_BANK0 5
`define ST_BANK1 6
`define ST_IBANK 7
`define STATUS_RST 8'h18
`define CTRL_RUN 0
`define CTRL_PLL 1
`define CTRL_RST 2'h1
// ----------------------------------------------------------------
// Opcodes in instruction bits 13:10; jump prefix in bits 13:11
// ----------------------------------------------------------------
`define OP_NOP 4'h0
`define OP_STOREW 4'h1
`define OP_CLEAR 4'h2
`define OP_ADDWF 4'h3
`define OP_SUBWF 4'h4
`define OP_SWAPNIB 4'h5
`define OP_MOVF 4'h6
`define OP_BITCLR 4'h7
`define OP_BITSET 4'h8
`define OP_MOVLW 4'h9
`define OP_ADDLW 4'hA
`define OP_SUBLW 4'hB
`define JUMP_PFX 3'h7
`define PHASE_RST 4'h1
`endif

// ===== core_phase_pipeline_status.v
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "core_consts.vh"
module core_phase_pipeline_status (
	input wire CLK_I,
	input wire RESETN_I,
	input wire [7:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	input wire [3:0] AVS_BYTEENABLE_I,
	output reg [31:0] AVS_READDATA_O,
	output reg AVS_WAITREQUEST_O,
	input wire WDT_TIMEOUT_I,
	input wire SLEEP_I,
	input wire CLRWDT_I,
	output reg [12:0] PM_ADDR_O,
	input wire [13:0] PM_DATA_I,
	output reg [8:0] DM_ADDR_O,
	output reg DM_RD_O,
	output reg DM_WR_O,
	output reg [7:0] DM_WDATA_O,
	input wire [7:0] DM_RDATA_I,
	output reg [3:0] PHASE_O,
	output reg FLUSH_O
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Core registers answer at the same low address in every bank
	function is_core;
		input [6:0] fa;
		begin
			is_core = (fa == `F_INDPORT) || (fa == `F_PCBYTE) ||
				(fa == `F_STATUS) || (fa == `F_PTR) ||
				(fa == `F_PCHI);
		end
	endfunction

	reg [1:0] ctrl_q;
	reg div_q;
	reg [12:0] pc_q;
	reg [13:0] ir_q;
	reg [7:0] w_q;
	reg [7:0] status_q;
	reg [7:0] status_d;
	reg [7:0] ptr_q;
	reg [4:0] pchi_q;
	reg [7:0] opnd_q;
	reg [7:0] res_q;
	reg [2:0] flg_q;
	reg [2:0] aff_q;
	reg wr_w_q;
	reg wr_core_q;

	// ------------------------------------------------------------
	// Clock source and phase enables
	// ------------------------------------------------------------
	// PLL path runs at full rate; direct path at half rate
	wire iclk_en = ctrl_q[`CTRL_PLL] | div_q;
	wire tick = iclk_en & ctrl_q[`CTRL_RUN];
	wire ph1 = tick & PHASE_O[0];
	wire ph2 = tick & PHASE_O[1];
	wire ph3 = tick & PHASE_O[2];
	wire ph4 = tick & PHASE_O[3];

	// Divider and phase rotation
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			div_q <= 1'b0;
			PHASE_O <= `PHASE_RST;
		end else begin
			div_q <= ~div_q;
			if (tick) begin
				PHASE_O <= {PHASE_O[2:0], PHASE_O[3]};
			end
		end
	end

	// ------------------------------------------------------------
	// Instruction decode
	// ------------------------------------------------------------
	// A flushed slot decodes as a no-op
	wire [3:0] op = FLUSH_O ? `OP_NOP : ir_q[13:10];
	wire is_jump = ~FLUSH_O & (ir_q[13:11] == `JUMP_PFX);
	wire [6:0] fa = ir_q[6:0];
	wire [2:0] bsel = ir_q[9:7];
	wire dbit = ir_q[7];
	wire [7:0] lit = ir_q[7:0];
	wire indir = (fa == `F_INDPORT);
	wire core_f = is_core(fa) & ~indir;
	// Direct address uses bank bits; indirect uses pointer
	wire [8:0] eff_addr = indir ?
		{status_q[`ST_IBANK], ptr_q} :
		{status_q[`ST_BANK1:`ST_BANK0], fa};

	// Core register read mux for read-modify-write on core files
	reg [7:0] core_rd;
	always @* begin
		case (fa)
		`F_PCBYTE: core_rd = pc_q[7:0];
		`F_STATUS: core_rd = status_q;
		`F_PTR: core_rd = ptr_q;
		`F_PCHI: core_rd = {3'h0, pchi_q};
		default: core_rd = 8'h00;
		endcase
	end

	wire [7:0] a_opnd = core_f ? core_rd : opnd_q;

	// ------------------------------------------------------------
	// Arithmetic and logic
	// ------------------------------------------------------------
	reg [8:0] sum;
	reg [4:0] nib;
	reg [7:0] alu_res;
	reg [2:0] aff;
	reg to_file;
	reg to_w;
	reg rd_f;
	reg do_add;
	reg [7:0] x;
	reg [7:0] y;
	reg cin;
	always @* begin
		alu_res = 8'h00;
		aff = 3'h0;
		to_file = 1'b0;
		to_w = 1'b0;
		rd_f = 1'b0;
		do_add = 1'b0;
		x = a_opnd;
		y = w_q;
		cin = 1'b0;
		if (!is_jump) begin
			case (op)
			`OP_STOREW: begin
				alu_res = w_q;
				to_file = 1'b1;
			end
			`OP_CLEAR: begin
				aff = 3'b100;
				to_file = 1'b1;
			end
			`OP_ADDWF: begin
				do_add = 1'b1;
				rd_f = 1'b1;
			end
			`OP_SUBWF: begin
				do_add = 1'b1;
				rd_f = 1'b1;
				y = ~w_q;
				cin = 1'b1;
			end
			`OP_SWAPNIB: begin
				alu_res = {a_opnd[3:0], a_opnd[7:4]};
				rd_f = 1'b1;
			end
			`OP_MOVF: begin
				alu_res = a_opnd;
				aff = 3'b100;
				rd_f = 1'b1;
			end
			`OP_BITCLR: begin
				alu_res = a_opnd & ~(8'h01 << bsel);
				rd_f = 1'b1;
				to_file = 1'b1;
			end
			`OP_BITSET: begin
				alu_res = a_opnd | (8'h01 << bsel);
				rd_f = 1'b1;
				to_file = 1'b1;
			end
			`OP_MOVLW: begin
				alu_res = lit;
				to_w = 1'b1;
			end
			`OP_ADDLW: begin
				do_add = 1'b1;
				x = lit;
				to_w = 1'b1;
			end
			`OP_SUBLW: begin
				do_add = 1'b1;
				x = lit;
				y = ~w_q;
				cin = 1'b1;
				to_w = 1'b1;
			end
			default: begin
				alu_res = 8'h00;
			end
			endcase
			// File-sourced ops other than bit clear/set pick destination from the d bit
			if (rd_f && (op != `OP_BITCLR) && (op != `OP_BITSET)) begin
				to_file = dbit;
				to_w = ~dbit;
			end
		end
		// Subtract is add of two's complement, so carry = no borrow
		sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
		nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
		if (do_add) begin
			alu_res = sum[7:0];
			aff = 3'b111;
		end
	end

	// Computed flags: zero, nibble carry, top carry
	wire z_flag = (alu_res == 8'h00);
	wire nib_flag = nib[4];
	wire c_flag = sum[8];
	wire [2:0] merged = ({flg_q[2], flg_q[1], flg_q[0]} & aff_q) |
		(status_q[2:0] & ~aff_q);

	// ------------------------------------------------------------
	// Register bus decode
	// ------------------------------------------------------------
	wire [5:0] idx = AVS_ADDRESS_I[7:2];
	// Write completes only at the edge where waitrequest is low
	wire bus_wr = AVS_WRITE_I & ~AVS_WAITREQUEST_O &
		AVS_BYTEENABLE_I[0];
	wire [7:0] bdat = AVS_WRITEDATA_I[7:0];
	wire core_commit = ph4 & wr_core_q;

	// ------------------------------------------------------------
	// Status next value
	// ------------------------------------------------------------
	// Bus writes land after the core so software wins a collision
	always @* begin
		status_d = status_q;
		if (ph4) begin
			status_d[2:0] = merged;
		end
		if (core_commit && (fa == `F_STATUS)) begin
			status_d[7:5] = res_q[7:5];
			// Flag-affecting ops keep computed flags
			if (aff_q == 3'h0) begin
				status_d[2:0] = res_q[2:0];
			end else begin
				status_d[2:0] = merged;
			end
		end
		if (bus_wr && (idx == `IDX_STATUS)) begin
			status_d[7:5] = bdat[7:5];
			status_d[2:0] = bdat[2:0];
		end
		// Reset-cause flags move only by hardware events
		if (CLRWDT_I) begin
			status_d[`ST_WDOG] = 1'b1;
			status_d[`ST_PWRDN] = 1'b1;
		end else if (SLEEP_I) begin
			status_d[`ST_WDOG] = 1'b1;
			status_d[`ST_PWRDN] = 1'b0;
		end
		if (WDT_TIMEOUT_I) begin
			status_d[`ST_WDOG] = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Pipeline and core registers
	// ------------------------------------------------------------
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			ctrl_q <= `CTRL_RST;
			pc_q <= 13'h0000;
			PM_ADDR_O <= 13'h0000;
			ir_q <= 14'h0000;
			FLUSH_O <= 1'b1;
			w_q <= 8'h00;
			status_q <= `STATUS_RST;
			ptr_q <= 8'h00;
			pchi_q <= 5'h00;
			opnd_q <= 8'h00;
			res_q <= 8'h00;
			flg_q <= 3'h0;
			aff_q <= 3'h0;
			wr_w_q <= 1'b0;
			wr_core_q <= 1'b0;
			DM_ADDR_O <= 9'h000;
			DM_RD_O <= 1'b0;
			DM_WR_O <= 1'b0;
			DM_WDATA_O <= 8'h00;
		end else begin
			status_q <= status_d;
			// Fetch address out, counter steps
			if (ph1) begin
				PM_ADDR_O <= pc_q;
				pc_q <= pc_q + 13'h0001;
				DM_ADDR_O <= eff_addr;
				DM_RD_O <= rd_f & ~core_f;
			end
			// Operand sampled at the close of phase two
			if (ph2) begin
				DM_RD_O <= 1'b0;
				opnd_q <= DM_RDATA_I;
			end
			// Result and flags settle; memory write opens
			if (ph3) begin
				res_q <= alu_res;
				flg_q <= {z_flag, nib_flag, c_flag};
				aff_q <= aff;
				wr_w_q <= to_w;
				wr_core_q <= to_file & core_f;
				DM_WDATA_O <= alu_res;
				DM_WR_O <= to_file & ~core_f;
			end
			if (ph4) begin
				DM_WR_O <= 1'b0;
				// Next word latched while this one retires
				ir_q <= PM_DATA_I;
				FLUSH_O <= 1'b0;
				aff_q <= 3'h0;
				if (wr_w_q) begin
					w_q <= res_q;
				end
				if (is_jump) begin
					// Prefetched slot dies; branch costs two cycles
					pc_q <= {pchi_q[4:3], ir_q[10:0]};
					FLUSH_O <= 1'b1;
				end
				if (core_commit) begin
					case (fa)
					`F_PCBYTE: begin
						pc_q <= {pchi_q, res_q};
						FLUSH_O <= 1'b1;
					end
					`F_PTR: ptr_q <= res_q;
					`F_PCHI: pchi_q <= res_q[4:0];
					default: ptr_q <= ptr_q;
					endcase
				end
			end
			if (bus_wr) begin
				case (idx)
				`IDX_PCBYTE: begin
					pc_q <= {pchi_q, bdat};
					FLUSH_O <= 1'b1;
				end
				`IDX_PTR: ptr_q <= bdat;
				`IDX_PCHI: pchi_q <= bdat[4:0];
				`IDX_CTRL: ctrl_q <= bdat[1:0];
				`IDX_WREG: w_q <= bdat;
				default: ctrl_q <= ctrl_q;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Register bus read mux and handshake
	// ------------------------------------------------------------
	// Indirect port holds no storage of its own, so the bus reads zero
	reg [7:0] rd_mux;
	always @* begin
		case (idx)
		`IDX_PCBYTE: rd_mux = pc_q[7:0];
		`IDX_STATUS: rd_mux = status_q;
		`IDX_PTR: rd_mux = ptr_q;
		`IDX_PCHI: rd_mux = {3'h0, pchi_q};
		`IDX_CTRL: rd_mux = {6'h00, ctrl_q};
		`IDX_WREG: rd_mux = w_q;
		`IDX_IREG: rd_mux = ir_q[7:0];
		default: rd_mux = 8'h00;
		endcase
	end

	// Fixed one wait cycle keeps the bus timing independent of phase
	always @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h00000000;
		end else if ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O) begin
			AVS_WAITREQUEST_O <= 1'b0;
			AVS_READDATA_O <= {24'h000000, rd_mux};
		end else begin
			AVS_WAITREQUEST_O <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== core_pipeline_props.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Timing checker for the phase sequencer and memory strobes
// ----
module core_pipeline_props (
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic [12:0] PM_ADDR_O,
	input wire logic [8:0] DM_ADDR_O,
	input wire logic DM_RD_O,
	input wire logic DM_WR_O,
	input wire logic [7:0] DM_WDATA_O,
	input wire logic [3:0] PHASE_O,
	input wire logic FLUSH_O
);
	// One clock domain, so clock and reset are given once
	default clocking @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	// Phases rotate one-hot and never stall while running
	phase_onehot_a: assert property ($onehot(PHASE_O))
		else $error("phase not one-hot");
	phase_order_a: assert property (
		$changed(PHASE_O) |-> PHASE_O ==
		{$past(PHASE_O[2:0]), $past(PHASE_O[3])})
		else $error("phase out of order");
	phase_pace_a: assert property (
		$changed(PHASE_O) |-> ##[1:2] $changed(PHASE_O))
		else $error("phase held too long");
	// Fetch address moves only as phase one ends
	pc_step_a: assert property (
		$changed(PM_ADDR_O) |-> PHASE_O == 4'h2)
		else $error("fetch address moved off phase one");
	flush_start_a: assert property (
		$rose(FLUSH_O) |-> PHASE_O == 4'h1)
		else $error("flush not aligned to ir load");
	// Data strobes belong to their phases
	read_phase_a: assert property (DM_RD_O |-> PHASE_O == 4'h2)
		else $error("operand read outside phase two");
	write_phase_a: assert property (DM_WR_O |-> PHASE_O == 4'h8)
		else $error("result write outside phase four");
	write_hold_a: assert property (
		DM_WR_O && $past(DM_WR_O) |-> $stable(DM_WDATA_O) &&
		$stable(DM_ADDR_O))
		else $error("write data moved mid strobe");
	// Every request gets exactly one wait cycle
	bus_wait_a: assert property (
		(AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=>
		!AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O)
		else $error("bus answer late or long");
	cover property ($rose(FLUSH_O));
	cover property ($rose(DM_WR_O));
	cover property (AVS_WRITE_I && !AVS_WAITREQUEST_O);
endmodule
bind core_phase_pipeline_status core_pipeline_props props (
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
	.PM_ADDR_O(PM_ADDR_O), .DM_ADDR_O(DM_ADDR_O), .DM_RD_O(DM_RD_O),
	.DM_WR_O(DM_WR_O), .DM_WDATA_O(DM_WDATA_O), .PHASE_O(PHASE_O),
	.FLUSH_O(FLUSH_O));
`default_nettype wire

// ===== core_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Program and data memory behind the core
// ----
module core_mem_model (
	input wire logic clk_i,
	input wire logic [12:0] pm_addr_i,
	output logic [13:0] pm_data_o,
	input wire logic [8:0] dm_addr_i,
	input wire logic dm_rd_i,
	input wire logic dm_wr_i,
	input wire logic [7:0] dm_wdata_i,
	output logic [7:0] dm_rdata_o
);
	logic [13:0] pm [0:8191];
	logic [7:0] dm [0:511];
	// Marker fill shows any stray write
	initial begin
		for (int i = 0; i < 8192; i++) begin
			pm[i] = 14'h0000;
		end
		for (int i = 0; i < 512; i++) begin
			dm[i] = 8'hA5;
		end
	end
	// Idle read bus shows inverted data so stale values never match
	assign pm_data_o = pm[pm_addr_i];
	assign dm_rdata_o = dm_rd_i ? dm[dm_addr_i] : ~dm[dm_addr_i];
	// Destination written while the strobe is high
	always @(posedge clk_i) begin
		if (dm_wr_i) begin
			dm[dm_addr_i] <= dm_wdata_i;
		end
	end
endmodule
`default_nettype wire

// ===== core_phase_pipeline_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "core_consts.vh"
// ----
// Register bus and program driven bench
// ----
module core_phase_pipeline_status_tb;
	logic CLK_I = 1'b0;
	logic RESETN_I = 1'b0;
	logic [7:0] AVS_ADDRESS_I = 8'h00;
	logic AVS_READ_I = 1'b0;
	logic AVS_WRITE_I = 1'b0;
	logic [31:0] AVS_WRITEDATA_I = 32'h00000000;
	logic [31:0] AVS_READDATA_O;
	logic AVS_WAITREQUEST_O;
	logic WDT_TIMEOUT_I = 1'b0;
	logic SLEEP_I = 1'b0;
	logic CLRWDT_I = 1'b0;
	logic [12:0] PM_ADDR_O;
	logic [13:0] PM_DATA_I;
	logic [8:0] DM_ADDR_O;
	logic DM_RD_O;
	logic DM_WR_O;
	logic [7:0] DM_WDATA_O;
	logic [7:0] DM_RDATA_I;
	logic [3:0] PHASE_O;
	logic FLUSH_O;
	logic [3:0] ph;
	int bad_count = 0;
	int total_checks = 0;
	// Flag arithmetic, bank switch, status clear, jump and flush
	logic [13:0] prog [0:15] = '{
		14'h240F, 14'h2801, 14'h04A0, 14'h1803,
		14'h04A1, 14'h2C1A, 14'h1803, 14'h04A2,
		14'h2283, 14'h04A3, 14'h0883, 14'h380E,
		14'h2455, 14'h04A4, 14'h0C83, 14'h380F};

	always #5 CLK_I = ~CLK_I;

	core_phase_pipeline_status dut (
		.CLK_I(CLK_I), .RESETN_I(RESETN_I),
		.AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
		.AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
		.AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(AVS_READDATA_O),
		.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
		.WDT_TIMEOUT_I(WDT_TIMEOUT_I), .SLEEP_I(SLEEP_I),
		.CLRWDT_I(CLRWDT_I), .PM_ADDR_O(PM_ADDR_O), .PM_DATA_I(PM_DATA_I),
		.DM_ADDR_O(DM_ADDR_O), .DM_RD_O(DM_RD_O), .DM_WR_O(DM_WR_O),
		.DM_WDATA_O(DM_WDATA_O), .DM_RDATA_I(DM_RDATA_I),
		.PHASE_O(PHASE_O), .FLUSH_O(FLUSH_O));

	core_mem_model mem (
		.clk_i(CLK_I), .pm_addr_i(PM_ADDR_O), .pm_data_o(PM_DATA_I),
		.dm_addr_i(DM_ADDR_O), .dm_rd_i(DM_RD_O), .dm_wr_i(DM_WR_O),
		.dm_wdata_i(DM_WDATA_O), .dm_rdata_o(DM_RDATA_I));

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// Request held until waitrequest is sampled low
	task automatic bus_op(input logic wr, input logic [5:0] idx,
		input logic [7:0] val, output logic [31:0] rd);
		int k;
		k = 0;
		@(posedge CLK_I);
		AVS_ADDRESS_I <= {idx, 2'b00};
		AVS_WRITEDATA_I <= {24'h000000, val};
		AVS_WRITE_I <= wr;
		AVS_READ_I <= ~wr;
		@(posedge CLK_I);
		while (AVS_WAITREQUEST_O !== 1'b0 && k < 20) begin
			k++;
			@(posedge CLK_I);
		end
		rd = AVS_READDATA_O;
		AVS_WRITE_I <= 1'b0;
		AVS_READ_I <= 1'b0;
		if (k == 20) begin
			bad_count++;
			print_verdict();
		end
	endtask

	task automatic reg_chk(input logic [5:0] idx, input logic [7:0] exp);
		logic [31:0] d;
		bus_op(1'b0, idx, 8'h00, d);
		check_eq(d, {24'h000000, exp});
	endtask

	task automatic reg_wr(input logic [5:0] idx, input logic [7:0] val);
		logic [31:0] d;
		bus_op(1'b1, idx, val, d);
	endtask

	task automatic dm_chk(input logic [8:0] a, input logic [7:0] exp);
		check_eq({24'h000000, mem.dm[a]}, {24'h000000, exp});
	endtask

	// Bounded wait for a fetch address; running out counts as a miss
	task automatic wait_addr(input logic [12:0] a);
		int k;
		k = 0;
		while (PM_ADDR_O !== a && k < 800) begin
			k++;
			@(posedge CLK_I);
		end
		check_eq({19'h00000, PM_ADDR_O}, {19'h00000, a});
		if (k == 800) begin
			print_verdict();
		end
	endtask

	// One-edge pulse on the watchdog, sleep and clear pins
	task automatic pulse(input logic [2:0] p);
		WDT_TIMEOUT_I <= p[0];
		SLEEP_I <= p[1];
		CLRWDT_I <= p[2];
		@(posedge CLK_I);
		WDT_TIMEOUT_I <= 1'b0;
		SLEEP_I <= 1'b0;
		CLRWDT_I <= 1'b0;
	endtask

	initial begin
		@(posedge CLK_I);
		for (int i = 0; i < 16; i++) begin
			mem.pm[i] = prog[i];
		end
		@(posedge CLK_I);
		RESETN_I <= 1'b1;
		reg_chk(`IDX_STATUS, 8'h18);
		reg_chk(`IDX_PCHI, 8'h00);
		reg_chk(`IDX_CTRL, 8'h01);
		reg_wr(6'h3F, 8'hFF);
		reg_chk(6'h3F, 8'h00);
		wait_addr(13'h0010);
		reg_chk(`IDX_STATUS, 8'h3A);
		reg_chk(`IDX_WREG, 8'h1F);
		dm_chk(9'h020, 8'h10);
		dm_chk(9'h021, 8'h1A);
		dm_chk(9'h022, 8'h1F);
		dm_chk(9'h0A3, 8'h1F);
		dm_chk(9'h024, 8'hA5);
		dm_chk(9'h083, 8'hA5);
		reg_wr(`IDX_PCHI, 8'h18);
		reg_chk(`IDX_PCHI, 8'h18);
		wait_addr(13'h180F);
		pulse(3'b001);
		reg_chk(`IDX_STATUS, 8'h2A);
		reg_wr(`IDX_STATUS, 8'h00);
		reg_chk(`IDX_STATUS, 8'h08);
		pulse(3'b010);
		reg_chk(`IDX_STATUS, 8'h10);
		pulse(3'b100);
		reg_chk(`IDX_STATUS, 8'h18);
		reg_wr(`IDX_CTRL, 8'h03);
		reg_chk(`IDX_CTRL, 8'h03);
		@(posedge CLK_I);
		ph = PHASE_O;
		@(posedge CLK_I);
		check_eq({28'h0000000, PHASE_O}, {28'h0000000, ph[2:0], ph[3]});
		print_verdict();
	end
endmodule
`default_nettype wire
